// ==== hw/crs_pkg.sv ====
/*
  crs_pkg: constants, opcodes and states of the core register set.
  assumes nothing beyond a SystemVerilog compiler; imported by crs_core_regs.
*/
package crs_pkg;

  // AHB register byte offsets
  localparam logic [7:0] REG_INDEX = 8'h00;
  localparam logic [7:0] REG_STACK = 8'h04;
  localparam logic [7:0] REG_PCNT = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0C;
  localparam logic [7:0] REG_ACC = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // reset values and fixed addresses
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] SP_LOW_RESET = 8'hFF;
  localparam logic [15:0] RESET_VEC = 16'hFFFE;
  localparam logic [15:0] BREAK_VEC = 16'hFFFC;
  localparam logic [15:0] BREAK_VEC_MON = 16'hFEFC;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] FLAGS_ONES = 8'h60;

  // condition flag bit positions
  localparam int FL_V = 7;
  localparam int FL_H = 4;
  localparam int FL_I = 3;
  localparam int FL_N = 2;
  localparam int FL_Z = 1;
  localparam int FL_C = 0;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OPD_LSB = 8;
  localparam int CMD_DATA_LSB = 16;

  // timing
  localparam int IMM_CYCLES = 2;
  localparam logic [15:0] BRANCH_LEN = 16'h0002;
  localparam logic [2:0] STACK_FRAME_LAST = 3'h4;

  typedef enum logic [7:0] {
    OP_NOP = 8'h00,
    OP_STKLO = 8'h01,
    OP_UNMASK = 8'h02,
    OP_IRET = 8'h04,
    OP_TRAP = 8'h05,
    OP_PUSHH = 8'h06,
    OP_PULLH = 8'h07,
    OP_DECADJ = 8'h08,
    OP_SUB = 8'h09,
    OP_BLT = 8'h0A,
    OP_JMP = 8'h0B,
    OP_FETCH = 8'h0C,
    OP_ASR = 8'h47,
    OP_ASL = 8'h48,
    OP_BGE = 8'h90,
    OP_AND = 8'hA4,
    OP_ADJSTK = 8'hA7,
    OP_ADC = 8'hA9,
    OP_ADD = 8'hAB,
    OP_ADJIDX = 8'hAF
  } crs_op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PUSH = 5'b00010,
    ST_PULL = 5'b00100,
    ST_VHI = 5'b01000,
    ST_VLO = 5'b10000
  } crs_state_t;

endpackage : crs_pkg

// ==== hw/crs_core_regs.sv ====
/*
  crs_core_regs: programmer-visible register set of an 8-bit core with its
  stacking, vector and flag logic, reached over an AHB-Lite slave.
  assumes a single-cycle-capable memory port on core_clk (req held until ack)
  and asynchronous irq/break pins, synchronised here.
*/
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
// Overview of operation
// - index register is upper byte concatenated with lower byte, 16 bits
// - reset loads stack pointer with 00FF
// - stack low byte reset op forces low byte FF, high byte kept
// - push decrements stack pointer, pull increments it
// - stack-relative address is stack pointer plus 8 or 16 bit offset
// - program counter steps after each fetch unless jump, branch or interrupt
// - after reset the vector at FFFE/FFFF loads the program counter
// - flag bits 6 and 5 always read one
// - overflow flag tracks signed overflow; signed branches test it
// - half-carry from bit 3 to 4 on add; decimal adjust uses it with carry
// - maskable requests ignored while mask bit set
// - interrupt entry stacks, then sets mask, then fetches vector
// - upper index byte is not stacked by interrupt entry
// - interrupt return pulls registers and restores mask from stack
// - reset sets mask; only unmask op or interrupt return's pulled flags clear it
// - sign flag copies result bit 7
// - zero flag set when result is 00
// - carry from bit 7 on add, borrow on subtract, shifts update it
// - break runs software trap after instruction, vector FFFC or FEFC
// - interrupt return in break handler ends break if request dropped
// - immediate adjust ops add sign-extended byte to SP or index, 2 cycles
`timescale 1ns/100ps
module crs_core_regs
  import crs_pkg::*;
#(
  parameter logic [15:0] IRQ_VEC = 16'hFFFA
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // memory port, same clock
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // asynchronous requests and straps
  input wire logic irq_req,
  input wire logic break_req,
  input wire logic break_en,
  input wire logic monitor_mode,
  // status
  output logic break_active
);

  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic irq_s, brk_s, brk_en_s, mon_s;
  logic [15:0] hx_q, sp_q, pc_q;
  logic [7:0] ccr_q, acc_q;
  crs_state_t st_q;
  logic [2:0] step_q;
  logic single_q;
  logic [15:0] vec_q;
  logic brk_active_q;
  logic [1:0] wait_q;
  logic cmd_pend_q;
  crs_op_t cmd_op_q;
  logic [7:0] cmd_opd_q;
  logic [15:0] cmd_data_q;
  logic wr_q, rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic ap_valid, wr_en, idle, irq_take, brk_take, take, go, mem_done, last;
  logic [15:0] sext_opd;
  logic [7:0] alu_res;
  logic alu_v, alu_h, alu_c;
  logic we_acc, we_v, we_h, we_c, we_nz;

  // level sync: first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {monitor_mode, break_en, break_req, irq_req};
      sync2_q <= sync1_q;
    end
  end
  assign irq_s = sync2_q[0];
  assign brk_s = sync2_q[1];
  assign brk_en_s = sync2_q[2];
  assign mon_s = sync2_q[3];

  function automatic logic [7:0] flags_view(input logic [7:0] f);
    flags_view = f | FLAGS_ONES;
  endfunction : flags_view

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    case (a)
      REG_INDEX: reg_read = {16'h0000, hx_q};
      REG_STACK: reg_read = {16'h0000, sp_q};
      REG_PCNT: reg_read = {16'h0000, pc_q};
      REG_FLAGS: reg_read = {24'h00_0000, flags_view(ccr_q)};
      REG_ACC: reg_read = {24'h00_0000, acc_q};
      // upper half: stack pointer plus latched offset; an 8-bit offset has a zero upper byte
      REG_STATUS: reg_read = {sp_q + cmd_data_q, 3'h0, st_q, 4'h0, brk_active_q, ccr_q[FL_I], cmd_pend_q,
                              (st_q != ST_IDLE) || (wait_q != 2'h0)};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  // ahb-lite: writes zero-wait, reads take one wait state so a read right
  // after a write always sees the written value
  assign ap_valid = hsel && hready && htrans[1];
  assign wr_en = wr_q && hready;
  assign hreadyout = !rd_pend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q <= ap_valid && hwrite && (hsize == 3'h2) && (haddr[31:8] == 24'h00_0000);
      rd_pend_q <= ap_valid && !hwrite;
      addr_q <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFC;
    end else begin
      rd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata_q <= reg_read(addr_q);
    end
  end

  // command latch: a write while one is pending is dropped
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmd_pend_q <= 1'b0;
      cmd_op_q <= OP_NOP;
      cmd_opd_q <= 8'h00;
      cmd_data_q <= 16'h0000;
    end else if (wr_en && addr_q == REG_CMD && !cmd_pend_q) begin
      cmd_pend_q <= 1'b1;
      cmd_op_q <= crs_op_t'(hwdata[CMD_OP_LSB +: 8]);
      cmd_opd_q <= hwdata[CMD_OPD_LSB +: 8];
      cmd_data_q <= hwdata[CMD_DATA_LSB +: 16];
    end else if (go) begin
      cmd_pend_q <= 1'b0;
    end
  end

  // sequencing
  assign idle = (st_q == ST_IDLE) && (wait_q == 2'h0);
  assign irq_take = idle && irq_s && !ccr_q[FL_I];
  assign brk_take = idle && brk_en_s && brk_s && !brk_active_q;
  assign take = irq_take || brk_take;
  assign go = idle && !take && cmd_pend_q;
  assign mem_done = mem_req && mem_ack;
  assign last = single_q || (step_q == STACK_FRAME_LAST);
  assign sext_opd = {{8{cmd_opd_q[7]}}, cmd_opd_q};

  assign mem_req = (st_q != ST_IDLE);
  assign mem_we = (st_q == ST_PUSH);
  assign break_active = brk_active_q;

  always_comb begin
    case (st_q)
      ST_PUSH: mem_addr = sp_q;
      ST_PULL: mem_addr = sp_q + 16'h0001;
      ST_VHI: mem_addr = vec_q;
      ST_VLO: mem_addr = vec_q + 16'h0001;
      default: mem_addr = 16'h0000;
    endcase
  end

  // frame: pc low, pc high, x, acc, flags; upper index byte stacked only by the single push op
  always_comb begin
    if (single_q) begin
      mem_wdata = hx_q[15:8];
    end else begin
      case (step_q)
        3'h0: mem_wdata = pc_q[7:0];
        3'h1: mem_wdata = pc_q[15:8];
        3'h2: mem_wdata = hx_q[7:0];
        3'h3: mem_wdata = acc_q;
        default: mem_wdata = flags_view(ccr_q);
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q <= ST_VHI;
      step_q <= 3'h0;
      single_q <= 1'b0;
      vec_q <= RESET_VEC;
      wait_q <= 2'h0;
    end else begin
      if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end
      case (st_q)
        ST_IDLE: begin
          step_q <= 3'h0;
          if (take) begin
            st_q <= ST_PUSH;
            single_q <= 1'b0;
            vec_q <= brk_take ? (mon_s ? BREAK_VEC_MON : BREAK_VEC) : IRQ_VEC;
          end else if (go) begin
            case (cmd_op_q)
              OP_TRAP: begin
                st_q <= ST_PUSH;
                single_q <= 1'b0;
                vec_q <= mon_s ? BREAK_VEC_MON : BREAK_VEC;
              end
              OP_IRET: begin
                st_q <= ST_PULL;
                single_q <= 1'b0;
              end
              OP_PUSHH: begin
                st_q <= ST_PUSH;
                single_q <= 1'b1;
              end
              OP_PULLH: begin
                st_q <= ST_PULL;
                single_q <= 1'b1;
              end
              OP_ADJSTK, OP_ADJIDX, OP_AND, OP_ADD, OP_ADC: wait_q <= 2'(IMM_CYCLES - 1);
              default: wait_q <= 2'h0;
            endcase
          end
        end
        ST_PUSH: begin
          if (mem_done) begin
            step_q <= step_q + 3'h1;
            if (last) begin
              st_q <= single_q ? ST_IDLE : ST_VHI;
            end
          end
        end
        ST_PULL: begin
          if (mem_done) begin
            step_q <= step_q + 3'h1;
            if (last) begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_VHI: begin
          if (mem_done) begin
            st_q <= ST_VLO;
          end
        end
        ST_VLO: begin
          if (mem_done) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      brk_active_q <= 1'b0;
    end else if (brk_take) begin
      brk_active_q <= 1'b1;
    end else if (st_q == ST_PULL && mem_done && last && !single_q && !brk_s) begin
      brk_active_q <= 1'b0;
    end
  end

  // alu and flag results
  always_comb begin
    logic [8:0] wide;
    logic [4:0] half;
    logic [7:0] corr;
    wide = 9'h000;
    half = 5'h00;
    corr = 8'h00;
    alu_res = acc_q;
    alu_v = 1'b0;
    alu_h = 1'b0;
    alu_c = 1'b0;
    we_acc = 1'b0;
    we_v = 1'b0;
    we_h = 1'b0;
    we_c = 1'b0;
    we_nz = 1'b0;
    case (cmd_op_q)
      OP_ADD, OP_ADC: begin
        wide = {1'b0, acc_q} + {1'b0, cmd_opd_q} + {8'h00, (cmd_op_q == OP_ADC) && ccr_q[FL_C]};
        half = {1'b0, acc_q[3:0]} + {1'b0, cmd_opd_q[3:0]} + {4'h0, (cmd_op_q == OP_ADC) && ccr_q[FL_C]};
        alu_res = wide[7:0];
        alu_c = wide[8];
        alu_h = half[4];
        alu_v = (acc_q[7] == cmd_opd_q[7]) && (wide[7] != acc_q[7]);
        {we_acc, we_v, we_h, we_c, we_nz} = 5'b11111;
      end
      OP_SUB: begin
        wide = {1'b0, acc_q} - {1'b0, cmd_opd_q};
        alu_res = wide[7:0];
        alu_c = wide[8];
        alu_v = (acc_q[7] != cmd_opd_q[7]) && (wide[7] != acc_q[7]);
        {we_acc, we_v, we_h, we_c, we_nz} = 5'b11011;
      end
      OP_AND: begin
        alu_res = acc_q & cmd_opd_q;
        alu_v = 1'b0;
        {we_acc, we_v, we_h, we_c, we_nz} = 5'b11001;
      end
      OP_ASL: begin
        alu_res = {acc_q[6:0], 1'b0};
        alu_c = acc_q[7];
        alu_v = acc_q[6] ^ acc_q[7];
        {we_acc, we_v, we_h, we_c, we_nz} = 5'b11011;
      end
      OP_ASR: begin
        alu_res = {acc_q[7], acc_q[7:1]};
        alu_c = acc_q[0];
        alu_v = acc_q[7] ^ acc_q[0];
        {we_acc, we_v, we_h, we_c, we_nz} = 5'b11011;
      end
      OP_DECADJ: begin
        corr[3:0] = (acc_q[3:0] > 4'h9 || ccr_q[FL_H]) ? 4'h6 : 4'h0;
        corr[7:4] = (acc_q > 8'h99 || ccr_q[FL_C]) ? 4'h6 : 4'h0;
        alu_res = acc_q + corr;
        alu_c = corr[7:4] != 4'h0;
        {we_acc, we_v, we_h, we_c, we_nz} = 5'b10011;
      end
      default: begin
        alu_res = acc_q;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ccr_q <= FLAGS_RESET;
    end else if (st_q == ST_PUSH && mem_done && last && !single_q) begin
      ccr_q[FL_I] <= 1'b1;
    end else if (st_q == ST_PULL && mem_done && !single_q && step_q == 3'h0) begin
      ccr_q <= flags_view(mem_rdata);
    end else if (go) begin
      if (cmd_op_q == OP_UNMASK) begin
        ccr_q[FL_I] <= 1'b0;
      end
      if (we_v) begin
        ccr_q[FL_V] <= alu_v;
      end
      if (we_h) begin
        ccr_q[FL_H] <= alu_h;
      end
      if (we_c) begin
        ccr_q[FL_C] <= alu_c;
      end
      if (we_nz) begin
        ccr_q[FL_N] <= alu_res[7];
        ccr_q[FL_Z] <= (alu_res == 8'h00);
      end
    end else if (wr_en && addr_q == REG_FLAGS) begin
      // software may not touch the mask bit here
      ccr_q <= {hwdata[FL_V], 2'b11, hwdata[FL_H], ccr_q[FL_I], hwdata[FL_N], hwdata[FL_Z], hwdata[FL_C]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      acc_q <= 8'h00;
    end else if (st_q == ST_PULL && mem_done && !single_q && step_q == 3'h1) begin
      acc_q <= mem_rdata;
    end else if (go && we_acc) begin
      acc_q <= alu_res;
    end else if (wr_en && addr_q == REG_ACC) begin
      acc_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sp_q <= SP_RESET;
    end else if (st_q == ST_PUSH && mem_done) begin
      sp_q <= sp_q - 16'h0001;
    end else if (st_q == ST_PULL && mem_done) begin
      sp_q <= sp_q + 16'h0001;
    end else if (go && cmd_op_q == OP_STKLO) begin
      sp_q <= {sp_q[15:8], SP_LOW_RESET};
    end else if (go && cmd_op_q == OP_ADJSTK) begin
      sp_q <= sp_q + sext_opd;
    end else if (wr_en && addr_q == REG_STACK) begin
      sp_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hx_q <= 16'h0000;
    end else if (st_q == ST_PULL && mem_done && single_q) begin
      hx_q[15:8] <= mem_rdata;
    end else if (st_q == ST_PULL && mem_done && step_q == 3'h2) begin
      hx_q[7:0] <= mem_rdata;
    end else if (go && cmd_op_q == OP_ADJIDX) begin
      hx_q <= hx_q + sext_opd;
    end else if (wr_en && addr_q == REG_INDEX) begin
      hx_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pc_q <= 16'h0000;
    end else if (st_q == ST_VHI && mem_done) begin
      pc_q[15:8] <= mem_rdata;
    end else if (st_q == ST_VLO && mem_done) begin
      pc_q[7:0] <= mem_rdata;
    end else if (st_q == ST_PULL && mem_done && !single_q && step_q == 3'h3) begin
      pc_q[15:8] <= mem_rdata;
    end else if (st_q == ST_PULL && mem_done && !single_q && step_q == 3'h4) begin
      pc_q[7:0] <= mem_rdata;
    end else if (go) begin
      case (cmd_op_q)
        OP_FETCH: pc_q <= pc_q + 16'h0001;
        OP_JMP: pc_q <= cmd_data_q;
        OP_BGE: pc_q <= pc_q + BRANCH_LEN + ((ccr_q[FL_N] ^ ccr_q[FL_V]) ? 16'h0000 : sext_opd);
        OP_BLT: pc_q <= pc_q + BRANCH_LEN + ((ccr_q[FL_N] ^ ccr_q[FL_V]) ? sext_opd : 16'h0000);
        default: pc_q <= pc_q;
      endcase
    end else if (wr_en && addr_q == REG_PCNT) begin
      pc_q <= hwdata[15:0];
    end
  end

endmodule : crs_core_regs

// ==== tb/crs_core_regs_chk.sv ====
/*
  crs_core_regs_chk: port-level assertions on the core register set.
  assumes crs_pkg is compiled first; bound into every crs_core_regs.
*/
`timescale 1ns/100ps
module crs_core_regs_chk
  import crs_pkg::*;
#(
  parameter logic [15:0] IRQ_VEC = 16'hFFFA
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  // break
  input wire logic break_req,
  input wire logic break_en,
  input wire logic monitor_mode,
  input wire logic break_active
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  property p_vec_first;
    $rose(reset_n) |-> mem_req && !mem_we && mem_addr == RESET_VEC;
  endproperty
  a_vec_first: assert property (p_vec_first) else $error("no vector fetch after reset");
  property p_vec_lo;
    mem_req && !mem_we && mem_ack && mem_addr == RESET_VEC |=> mem_req && mem_addr == 16'hFFFF;
  endproperty
  a_vec_lo: assert property (p_vec_lo) else $error("vector low byte not fetched");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request changed before ack");
  property p_push_dec;
    mem_req && mem_we && mem_ack ##1 mem_req && mem_we |-> mem_addr == $past(mem_addr) - 16'h0001;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push address not decremented");
  property p_pull_inc;
    mem_req && !mem_we && mem_ack ##1 mem_req && !mem_we |-> mem_addr == $past(mem_addr) + 16'h0001;
  endproperty
  a_pull_inc: assert property (p_pull_inc) else $error("pull address not incremented");
  // a read straight after stacking can only be the vector fetch
  property p_mask_vec;
    mem_req && mem_we && mem_ack ##1 mem_req && !mem_we |-> mem_addr inside {IRQ_VEC, BREAK_VEC, BREAK_VEC_MON};
  endproperty
  a_mask_vec: assert property (p_mask_vec) else $error("stacking not followed by vector");
  property p_brk_vec;
    $rose(break_active) |-> ##[1:60] mem_req && !mem_we && mem_addr == (monitor_mode ? BREAK_VEC_MON : BREAK_VEC);
  endproperty
  a_brk_vec: assert property (p_brk_vec) else $error("break vector not fetched");
  property p_brk_en;
    $rose(break_active) |-> break_en;
  endproperty
  a_brk_en: assert property (p_brk_en) else $error("break taken while disabled");
  property p_brk_end;
    $fell(break_active) |-> !break_req;
  endproperty
  a_brk_end: assert property (p_brk_end) else $error("break ended with request high");
  property p_rd_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
endmodule : crs_core_regs_chk

bind crs_core_regs crs_core_regs_chk #(.IRQ_VEC(IRQ_VEC)) i_crs_core_regs_chk (.core_clk, .reset_n, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .mem_req, .mem_we, .mem_addr, .mem_ack, .break_req, .break_en,
  .monitor_mode, .break_active);

// ==== tb/crs_mem_model.sv ====
/*
  crs_mem_model: byte memory with vector table on the core's memory port.
  assumes core_clk and reset_n shared with the core; lat sets ack delay.
*/
`timescale 1ns/100ps
module crs_mem_model (
  // clock, reset, speed
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] lat,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_q;

  initial begin
    mem[16'hFFFE] = 8'h10;
    mem[16'hFFFF] = 8'h00;
    mem[16'hFFFA] = 8'h30;
    mem[16'hFFFB] = 8'h00;
    mem[16'hFFFC] = 8'h40;
    mem[16'hFFFD] = 8'h00;
    mem[16'hFEFC] = 8'h50;
    mem[16'hFEFD] = 8'h00;
  end

  // all 64k is ram, so any stack position the bench uses is legal
  always @(posedge core_clk) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 8'h5A;
    end else if (mem_req && !mem_ack && wait_q >= lat) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
      mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr];
      if (mem_we) begin
        mem[mem_addr] <= mem_wdata;
      end
    end else begin
      // data toggles off the ack so a stale byte can never pass
      mem_ack <= 1'b0;
      wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : crs_mem_model

// ==== tb/tb_top.sv ====
/*
  tb_top: self-checking bench for crs_core_regs with a memory model.
  assumes crs_pkg, the design, checker and memory model compiled first.
*/
`timescale 1ns/100ps
module tb_top
  import crs_pkg::*;
;
  logic core_clk, reset_n, hsel, hwrite, hreadyout, hresp, mem_req, mem_we, mem_ack;
  logic irq_req, break_req, break_en, monitor_mode, break_active;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, lat;
  logic [2:0] hsize;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  int fails, checks_done;

  crs_core_regs i_crs_core_regs (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .irq_req, .break_req, .break_en, .monitor_mode, .break_active);
  crs_mem_model i_crs_mem_model (.core_clk, .reset_n, .lat, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);

  always #50 core_clk = ~core_clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ready is looked at before the edge, so the design's own update never races it
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    logic rdy;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(negedge core_clk);
      rdy = hreadyout;
      @(posedge core_clk);
    end while (rdy !== 1'b1 && ++n < 40);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge core_clk);
      rdy = hreadyout;
      q = hrdata;
      @(posedge core_clk);
    end while (rdy !== 1'b1 && ++n < 40);
    chk({31'h0, rdy}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd_chk

  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      ahb(1'b0, a, 32'h0, q);
    end while ((q & m) !== e && ++n < 60);
    chk(q & m, e);
  endtask : poll

  task automatic cmd(input logic [7:0] op, input logic [7:0] opd = 8'h0, input logic [15:0] t = 16'h0);
    wr(REG_CMD, {t, opd, op});
    poll(REG_STATUS, 32'h3, 32'h0);
  endtask : cmd

  task automatic mchk(input logic [15:0] a, input logic [7:0] e);
    chk({24'h0, i_crs_mem_model.mem[a]}, {24'h0, e});
  endtask : mchk

  task automatic rst();
    reset_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    poll(REG_STATUS, 32'h3, 32'h0);
  endtask : rst

  task automatic t_reset();
    rd_chk(REG_STACK, 32'h00FF);
    rd_chk(REG_PCNT, 32'h1000);
    rd_chk(REG_INDEX, 32'h0);
    wr(REG_FLAGS, 32'h0);
    rd_chk(REG_FLAGS, 32'h68);
    rd_chk(8'h1C, 32'h0);
  endtask : t_reset

  task automatic t_adjust();
    wr(REG_INDEX, 32'h1234);
    rd_chk(REG_INDEX, 32'h1234);
    cmd(OP_ADJIDX, 8'hFE);
    rd_chk(REG_INDEX, 32'h1232);
    wr(REG_STACK, 32'h0234);
    cmd(OP_STKLO);
    rd_chk(REG_STACK, 32'h02FF);
    cmd(OP_ADJSTK, 8'h10);
    rd_chk(REG_STACK, 32'h030F);
    cmd(OP_ADJSTK, 8'hF0);
    rd_chk(REG_STACK, 32'h02FF);
    rd_chk(REG_FLAGS, 32'h68);
  endtask : t_adjust

  task automatic t_alu();
    // op, a, m, flags in, a out, flags out
    logic [47:0] tab [9] = '{48'hAB08_0868_1078, 48'hAB7F_0168_80FC, 48'hABFF_0168_007B,
      48'hA90F_0069_1078, 48'hA4F0_0FE8_006A, 48'h0900_0168_FF6D, 48'h4880_0068_00EB,
      48'h4781_0068_C06D, 48'h0810_0078_1678};
    for (int i = 0; i < 9; i++) begin
      wr(REG_ACC, {24'h0, tab[i][39:32]});
      wr(REG_FLAGS, {24'h0, tab[i][23:16]});
      cmd(tab[i][47:40], tab[i][31:24]);
      rd_chk(REG_ACC, {24'h0, tab[i][15:8]});
      rd_chk(REG_FLAGS, {24'h0, tab[i][7:0]});
    end
  endtask : t_alu

  task automatic t_flow();
    wr(REG_PCNT, 32'h1000);
    wr(REG_FLAGS, 32'hE8);
    cmd(OP_BGE, 8'h10);
    rd_chk(REG_PCNT, 32'h1002);
    cmd(OP_BLT, 8'h10);
    rd_chk(REG_PCNT, 32'h1014);
    cmd(OP_JMP, 8'h0, 16'h2345);
    rd_chk(REG_PCNT, 32'h2345);
    rd_chk(REG_STATUS, 32'h2644_0104);
    cmd(OP_FETCH);
    rd_chk(REG_PCNT, 32'h2346);
  endtask : t_flow

  task automatic t_stack();
    lat <= 2'h2;
    wr(REG_STACK, 32'h00FF);
    wr(REG_INDEX, 32'hAB00);
    cmd(OP_PUSHH);
    mchk(16'h00FF, 8'hAB);
    rd_chk(REG_STACK, 32'h00FE);
    wr(REG_INDEX, 32'h0);
    cmd(OP_PULLH);
    rd_chk(REG_INDEX, 32'hAB00);
    rd_chk(REG_STACK, 32'h00FF);
    lat <= 2'h0;
  endtask : t_stack

  task automatic t_irq();
    logic [7:0] fr [5] = '{8'h34, 8'h12, 8'h77, 8'h55, 8'h60};
    lat <= 2'h1;
    wr(REG_PCNT, 32'h1234);
    wr(REG_ACC, 32'h55);
    wr(REG_INDEX, 32'h9977);
    wr(REG_FLAGS, 32'h60);
    irq_req <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd_chk(REG_STACK, 32'h00FF);
    cmd(OP_UNMASK);
    poll(REG_STACK, 32'hFFFF, 32'h00FA);
    poll(REG_STATUS, 32'h3, 32'h0);
    irq_req <= 1'b0;
    rd_chk(REG_PCNT, 32'h3000);
    rd_chk(REG_FLAGS, 32'h68);
    for (int i = 0; i < 5; i++) begin
      mchk(16'h00FF - i[15:0], fr[i]);
    end
    wr(REG_INDEX, 32'h1100);
    wr(REG_ACC, 32'h0);
    cmd(OP_IRET);
    rd_chk(REG_PCNT, 32'h1234);
    rd_chk(REG_FLAGS, 32'h60);
    rd_chk(REG_INDEX, 32'h1177);
    rd_chk(REG_ACC, 32'h55);
    rd_chk(REG_STACK, 32'h00FF);
  endtask : t_irq

  task automatic t_break();
    break_req <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk({31'h0, break_active}, 32'h0);
    for (int m = 0; m < 2; m++) begin
      monitor_mode <= m[0];
      break_req <= 1'b1;
      break_en <= 1'b1;
      poll(REG_STACK, 32'hFFFF, 32'h00FA);
      poll(REG_STATUS, 32'h3, 32'h0);
      chk({31'h0, break_active}, 32'h1);
      rd_chk(REG_PCNT, m ? 32'h5000 : 32'h4000);
      break_req <= 1'b0;
      repeat (4) @(posedge core_clk);
      cmd(OP_IRET);
      chk({31'h0, break_active}, 32'h0);
      rd_chk(REG_PCNT, 32'h1234);
    end
    cmd(OP_TRAP);
    rd_chk(REG_PCNT, 32'h5000);
    rd_chk(REG_STACK, 32'h00FA);
  endtask : t_break

  task automatic t_reset2();
    wr(REG_STACK, 32'h0123);
    rst();
    rd_chk(REG_STACK, 32'h00FF);
    rd_chk(REG_FLAGS, 32'h68);
  endtask : t_reset2

  initial begin
    core_clk = 1'b0;
    reset_n <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    irq_req <= 1'b0;
    break_req <= 1'b0;
    break_en <= 1'b0;
    monitor_mode <= 1'b0;
    lat <= 2'h0;
    rst();
    t_reset();
    t_adjust();
    t_alu();
    t_flow();
    t_stack();
    t_irq();
    t_break();
    t_reset2();
    summarize();
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule : tb_top
